// ### rtl/gsc_link_if.sv
// Purpose: Carries the participation state between the register bank and its sequencer.
// Assumes: Both ends run on the same clock.
// Notes: The register bank owns configuration and the control-word valid bit.
`timescale 1ns/1ps
interface gsc_link_if;
  logic online;
  gsc_pkg::gsc_state_t state;
  logic words_en;
  logic startup_lock;
  logic ctrl_dv;

  modport seq (output online, output state, input words_en, input startup_lock, input ctrl_dv);
  modport regs (input online, input state, output words_en, output startup_lock, output ctrl_dv);
endinterface

// ### rtl/gsc_pkg.sv
// Purpose: Shared constants and types for the gateway control and status word block.
// Assumes: Byte-wide process-data access from the fieldbus side, one clock domain.
// Notes: Words are held most significant byte first at the even byte address.
package gsc_pkg;

  localparam int ADDR_W = 10;

  // Byte addresses of the two words in the process-data areas.
  localparam logic [9:0] STATUS_HI_ADDR = 10'h000;
  localparam logic [9:0] STATUS_LO_ADDR = 10'h001;
  localparam logic [9:0] CTRL_HI_ADDR = 10'h200;
  localparam logic [9:0] CTRL_LO_ADDR = 10'h201;

  // Status word field positions.
  localparam int ST_SEND_BIT = 15;
  localparam int ST_CONFIRM_BIT = 14;
  localparam int ST_DV_BIT = 13;
  localparam int ST_CODE_MSB = 12;
  localparam int ST_CODE_LSB = 8;

  // Control word field positions.
  localparam int CT_CONFIRM_BIT = 15;
  localparam int CT_SEND_BIT = 14;
  localparam int CT_DV_BIT = 13;

  // Reset values.
  localparam logic [4:0] CODE_NO_ERROR = 5'h1f;
  localparam logic [7:0] STATUS_DATA_RESET = 8'h00;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // Fieldbus participation sequence.
  typedef enum logic [1:0] {
    GSC_OFFLINE = 2'b00,
    GSC_ONLINE_WAIT = 2'b01,
    GSC_EXCHANGE = 2'b10
  } gsc_state_t;

endpackage

// ### rtl/gsc_sequencer.sv
// Purpose: Synchronises the fieldbus online level and runs the participation sequence.
// Assumes: The online pin is asynchronous to i_clk.
// Notes: A change of online counts only once the second and third stages agree.
`timescale 1ns/1ps
module gsc_sequencer (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_fb_online,
  gsc_link_if.seq lnk
);

  logic sync1;
  logic sync2;
  logic sync3;
  logic online;
  gsc_pkg::gsc_state_t state;
  gsc_pkg::gsc_state_t next_state;
  wire lock_active = lnk.words_en && lnk.startup_lock;
  wire may_start = !lock_active || lnk.ctrl_dv;

  // Three-stage synchroniser; the first stage feeds only the second.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
      online <= 1'b0;
    end else begin
      sync1 <= i_fb_online;
      sync2 <= sync1;
      sync3 <= sync2;
      if (sync2 == sync3) begin
        online <= sync2;
      end
    end
  end

  // Going offline from either online state always restarts the sequence.
  always_comb begin
    next_state = state;
    unique case (state)
      gsc_pkg::GSC_OFFLINE: begin
        if (online) next_state = gsc_pkg::GSC_ONLINE_WAIT;
      end
      gsc_pkg::GSC_ONLINE_WAIT: begin
        if (!online) next_state = gsc_pkg::GSC_OFFLINE; // R08
        else if (may_start) next_state = gsc_pkg::GSC_EXCHANGE; // R04 R05
      end
      gsc_pkg::GSC_EXCHANGE: begin
        if (!online) next_state = gsc_pkg::GSC_OFFLINE; // R08
      end
      default: next_state = gsc_pkg::GSC_OFFLINE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) state <= gsc_pkg::GSC_OFFLINE;
    else state <= next_state;
  end

  assign lnk.online = online;
  assign lnk.state = state;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  sequence s_locked_wait;
    (state == gsc_pkg::GSC_ONLINE_WAIT) && online && lock_active && !lnk.ctrl_dv;
  endsequence

  property p_lock_holds;
    s_locked_wait |=> (state != gsc_pkg::GSC_EXCHANGE);
  endproperty
  a_lock_holds: assert property (p_lock_holds) else $error("Exchange began under start-up lock."); // R04

  property p_free_start;
    (state == gsc_pkg::GSC_ONLINE_WAIT) && online && !lock_active |=> (state == gsc_pkg::GSC_EXCHANGE);
  endproperty
  a_free_start: assert property (p_free_start) else $error("Exchange did not start without lock."); // R05

  sequence s_drop;
    (state != gsc_pkg::GSC_OFFLINE) && !online;
  endsequence

  property p_offline_return;
    s_drop |=> (state == gsc_pkg::GSC_OFFLINE) ##1 (state != gsc_pkg::GSC_EXCHANGE);
  endproperty
  a_offline_return: assert property (p_offline_return) else $error("Offline did not restart sequence."); // R08

endmodule

// ### rtl/gsc_top.sv
// Purpose: Control and status word bank of a serial-to-fieldbus gateway.
// Assumes: The fieldbus side reads and writes process data one byte per cycle.
// Notes: Reads answer one cycle after the strobe; other addresses read zero here.
//
// Overview of operation
// R01: Both words stay disabled by default and appear only when configuration enables them.
// R02: Status word sits at input bytes 0-1, control word at output bytes 0x200-0x201.
// R03: Each word is held most significant byte first.
// R04: Enabled with start-up lock, exchange waits for control-word data-valid.
// R05: Disabled or no lock, exchange starts as soon as the fieldbus is online.
// R06: Control system clears its valid bit offline and writes initial outputs.
// R07: Control system sets its valid bit after gateway's bit clears, then exchanges.
// R08: Going offline from any online state restarts the handshake.
// R09: The gateway never clears the status data-valid bit on its own.
// R10: Control system should not wait for status data-valid before talking to nodes.
// R11: Status data-valid is set only after every transaction has completed.
// R12: Status bit 13 is set once all transactions succeeded at least once.
// R13: Status bits 12 to 8 carry the last status code; 0x1f means no error.
// R14: Status bits 15 and 14 carry the send and confirm handshake flags.
`timescale 1ns/1ps
module gsc_top (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_words_en,
  input wire logic i_startup_lock,
  input wire logic i_fb_online,
  input wire logic [9:0] i_fb_addr,
  input wire logic i_fb_rd,
  input wire logic i_fb_wr,
  input wire logic [7:0] i_fb_wdata,
  input wire logic i_all_txn_done,
  input wire logic i_report_valid,
  input wire logic [4:0] i_report_code,
  input wire logic [7:0] i_report_data,
  output logic o_report_ready,
  output logic [7:0] o_fb_rdata,
  output logic o_exchange_en,
  output logic [15:0] o_ctrl_word,
  output logic o_status_dv
);

  gsc_link_if lnk ();

  gsc_sequencer u_seq (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_fb_online(i_fb_online),
    .lnk(lnk)
  );

  logic [15:0] ctrl;
  logic status_send;
  logic status_dv;
  logic [4:0] status_code;
  logic [7:0] status_data;
  logic online_d;

  // Lane decode shared by all four byte addresses; a disabled word never matches.
  function automatic logic addr_hit(input logic en, input logic [9:0] addr, input logic [9:0] lane);
    return en && (addr == lane);
  endfunction

  // Address decode; the words only exist while configuration enables them.
  wire hit_st_hi = addr_hit(i_words_en, i_fb_addr, gsc_pkg::STATUS_HI_ADDR); // R01 R02
  wire hit_st_lo = addr_hit(i_words_en, i_fb_addr, gsc_pkg::STATUS_LO_ADDR); // R01 R02
  wire hit_ct_hi = addr_hit(i_words_en, i_fb_addr, gsc_pkg::CTRL_HI_ADDR); // R01 R02
  wire hit_ct_lo = addr_hit(i_words_en, i_fb_addr, gsc_pkg::CTRL_LO_ADDR); // R01 R02

  // Assembled status word: send, confirm, valid, code, data.
  wire status_confirm = ctrl[gsc_pkg::CT_SEND_BIT]; // R14
  wire [15:0] status_word = {status_send, status_confirm, status_dv, status_code, status_data}; // R12 R13 R14

  // Most significant byte answers at the even address.
  wire [7:0] read_byte = hit_st_hi ? status_word[15:8] : // R03
                         hit_st_lo ? status_word[7:0] :
                         hit_ct_hi ? ctrl[15:8] : // R03
                         hit_ct_lo ? ctrl[7:0] : gsc_pkg::BYTE_ZERO;

  // Control word writes; it is cleared while disabled so a stale valid bit cannot unlock.
  wire [15:0] next_ctrl = !i_words_en ? gsc_pkg::CTRL_RESET : // R01
                          (i_fb_wr && hit_ct_hi) ? {i_fb_wdata, ctrl[7:0]} : // R03
                          (i_fb_wr && hit_ct_lo) ? {ctrl[15:8], i_fb_wdata} : ctrl;

  // A new report is taken only once the previous one has been confirmed.
  wire report_take = i_report_valid && o_report_ready; // R14
  wire next_send = report_take ? !status_send : status_send; // R14
  wire next_ready = (next_send == next_ctrl[gsc_pkg::CT_CONFIRM_BIT]);

  // Valid bit: set only in exchange after all transactions; cleared only by the offline
  // restart, never spontaneously. A set in the same cycle wins.
  wire went_offline = online_d && !lnk.online; // R08
  wire dv_set = (lnk.state == gsc_pkg::GSC_EXCHANGE) && i_all_txn_done; // R11 R12
  wire next_dv = dv_set ? 1'b1 : (went_offline ? 1'b0 : status_dv); // R09

  wire next_exchange = (lnk.state == gsc_pkg::GSC_EXCHANGE) && lnk.online; // R04 R05

  assign lnk.words_en = i_words_en;
  assign lnk.startup_lock = i_startup_lock;
  assign lnk.ctrl_dv = ctrl[gsc_pkg::CT_DV_BIT]; // R04

  // Control word and handshake flags.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl <= gsc_pkg::CTRL_RESET;
      status_send <= 1'b0;
      o_report_ready <= 1'b1;
    end else begin
      ctrl <= next_ctrl;
      status_send <= next_send;
      o_report_ready <= next_ready;
    end
  end

  // Status code and data hold the last report until the next one.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      status_code <= gsc_pkg::CODE_NO_ERROR;
      status_data <= gsc_pkg::STATUS_DATA_RESET;
    end else if (report_take) begin
      status_code <= i_report_code; // R13
      status_data <= i_report_data;
    end
  end

  // Valid bit and online history.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      status_dv <= 1'b0;
      online_d <= 1'b0;
    end else begin
      status_dv <= next_dv;
      online_d <= lnk.online;
    end
  end

  // Registered outputs; read data holds between reads.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_fb_rdata <= gsc_pkg::BYTE_ZERO;
      o_exchange_en <= 1'b0;
      o_ctrl_word <= gsc_pkg::CTRL_RESET;
      o_status_dv <= 1'b0;
    end else begin
      if (i_fb_rd) o_fb_rdata <= read_byte;
      o_exchange_en <= next_exchange;
      o_ctrl_word <= next_ctrl;
      o_status_dv <= next_dv;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  property p_disabled_read;
    i_fb_rd && !i_words_en |=> (o_fb_rdata == gsc_pkg::BYTE_ZERO);
  endproperty
  a_disabled_read: assert property (p_disabled_read) else $error("Disabled word was readable."); // R01

  property p_status_msb;
    i_fb_rd && i_words_en && (i_fb_addr == gsc_pkg::STATUS_HI_ADDR) |=> (o_fb_rdata == $past(status_word[15:8]));
  endproperty
  a_status_msb: assert property (p_status_msb) else $error("Status upper byte not at even address."); // R02

  property p_ctrl_msb;
    i_fb_wr && i_words_en && (i_fb_addr == gsc_pkg::CTRL_HI_ADDR) |=> (ctrl[15:8] == $past(i_fb_wdata));
  endproperty
  a_ctrl_msb: assert property (p_ctrl_msb) else $error("Control upper byte not written at even address."); // R03

  property p_dv_sticky;
    status_dv && !went_offline |=> status_dv;
  endproperty
  a_dv_sticky: assert property (p_dv_sticky) else $error("Status valid bit dropped spontaneously."); // R09

  property p_dv_set;
    (lnk.state == gsc_pkg::GSC_EXCHANGE) && i_all_txn_done |=> status_dv && o_status_dv;
  endproperty
  a_dv_set: assert property (p_dv_set) else $error("Status valid not set after transactions."); // R12

  property p_dv_cause;
    $rose(status_dv) |-> $past(dv_set);
  endproperty
  a_dv_cause: assert property (p_dv_cause) else $error("Status valid set without completion."); // R11

  property p_code_load;
    report_take |=> (status_code == $past(i_report_code)) && (status_send != $past(status_send));
  endproperty
  a_code_load: assert property (p_code_load) else $error("Report not loaded with send toggle."); // R13

  property p_hold_unconfirmed;
    !o_report_ready && !i_fb_wr |=> $stable(status_send) && $stable(status_code);
  endproperty
  a_hold_unconfirmed: assert property (p_hold_unconfirmed) else $error("Report changed before confirm."); // R14

  property p_status_lsb;
    i_fb_rd && i_words_en && (i_fb_addr == gsc_pkg::STATUS_LO_ADDR) |=> (o_fb_rdata == $past(status_word[7:0]));
  endproperty
  a_status_lsb: assert property (p_status_lsb) else $error("Status lower byte not at odd address."); // R02

  // The status word is read-only, so a write to its upper lane must leave the control word alone.
  property p_status_ro;
    i_fb_wr && i_words_en && (i_fb_addr == gsc_pkg::STATUS_HI_ADDR) |=> $stable(ctrl);
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("Status write changed the control word."); // R02

  property p_ctrl_lsb;
    i_fb_wr && i_words_en && (i_fb_addr == gsc_pkg::CTRL_LO_ADDR) |=> (ctrl[7:0] == $past(i_fb_wdata));
  endproperty
  a_ctrl_lsb: assert property (p_ctrl_lsb) else $error("Control lower byte not written at odd address."); // R03

  property p_ctrl_disabled;
    !i_words_en |=> (ctrl == gsc_pkg::CTRL_RESET) && (o_ctrl_word == gsc_pkg::CTRL_RESET);
  endproperty
  a_ctrl_disabled: assert property (p_ctrl_disabled) else $error("Control word kept while disabled."); // R01

  // The exchange enable lags the sequencer by one edge, so it is checked against the past state.
  property p_exch_state;
    o_exchange_en |-> $past(lnk.state == gsc_pkg::GSC_EXCHANGE) && $past(lnk.online);
  endproperty
  a_exch_state: assert property (p_exch_state) else $error("Exchange enabled outside the exchanging state."); // R04 R05

  property p_code_stands;
    !report_take |=> $stable(status_code) && $stable(status_data);
  endproperty
  a_code_stands: assert property (p_code_stands) else $error("Report code changed without a new report."); // R13

endmodule

// ### tb/gateway_status_control_handshake_test.sv
// Purpose: Self-checking bench for the control and status word bank.
// Assumes: 100 MHz clock, asynchronous active-low reset held 16 cycles.
// Notes: Scenarios run in order and each leaves the state the next one needs.
`timescale 1ns/1ps
module gateway_status_control_handshake_test;
  logic i_clk, i_rstn, i_words_en, i_startup_lock, i_all_txn_done;
  logic i_report_valid, o_report_ready, o_exchange_en, o_status_dv, ok;
  logic [4:0] i_report_code;
  logic [7:0] i_report_data, o_fb_rdata, s;
  logic [15:0] o_ctrl_word;
  logic [9:0] fb_addr;
  logic fb_rd, fb_wr, fb_online;
  logic [7:0] fb_wdata;
  int n_fail = 0;
  int total_checks = 0;

  gsc_top u_dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_words_en(i_words_en), .i_startup_lock(i_startup_lock),
    .i_fb_online(fb_online), .i_fb_addr(fb_addr), .i_fb_rd(fb_rd), .i_fb_wr(fb_wr), .i_fb_wdata(fb_wdata),
    .i_all_txn_done(i_all_txn_done), .i_report_valid(i_report_valid), .i_report_code(i_report_code),
    .i_report_data(i_report_data), .o_report_ready(o_report_ready), .o_fb_rdata(o_fb_rdata),
    .o_exchange_en(o_exchange_en), .o_ctrl_word(o_ctrl_word), .o_status_dv(o_status_dv));
  gsc_plc_model u_plc (.i_clk(i_clk), .i_rdata(o_fb_rdata), .o_addr(fb_addr), .o_rd(fb_rd), .o_wr(fb_wr),
    .o_wdata(fb_wdata), .o_online(fb_online));

  // Free-running clock.
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  // Compare and count.
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Bounded wait for the exchange level; the sync chain needs a few edges.
  task automatic wait_exch(input logic v);
    for (int i = 0; i < 20 && o_exchange_en !== v; i++) @(posedge i_clk);
    #1 chk(o_exchange_en, v);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Outputs straight after reset.
  task automatic t_reset();
    chk(o_report_ready, 1'b1);
    chk(o_exchange_en, 1'b0);
    chk(o_ctrl_word, 16'h0000);
    chk(o_status_dv, 1'b0);
    chk(o_fb_rdata, 8'h00);
  endtask
  // Words disabled: nothing mapped, exchange follows online alone.
  task automatic t_disabled();
    u_plc.wr(10'h200, 8'hff);
    #1 chk(o_ctrl_word, 16'h0000);
    u_plc.rd(10'h000, s);
    chk(s, 8'h1f & 8'h00);
    u_plc.online(1'b0, ok);
    wait_exch(1'b1);
    u_plc.offline(8'h11);
    wait_exch(1'b0);
  endtask
  // Enabled with lock: layout, byte order, read-only status, withheld exchange.
  task automatic t_lock();
    @(posedge i_clk);
    i_words_en <= 1'b1;
    i_startup_lock <= 1'b1;
    u_plc.wr(10'h000, 8'hc0);
    u_plc.rd(10'h000, s);
    chk(s, 8'h1f);
    u_plc.rd(10'h001, s);
    chk(s, 8'h00);
    u_plc.online(1'b0, ok);
    repeat (20) @(posedge i_clk);
    #1 chk(o_exchange_en, 1'b0);
    u_plc.wr(10'h200, 8'h20);
    wait_exch(1'b1);
    u_plc.wr(10'h201, 8'h5a);
    #1 chk(o_ctrl_word, 16'h205a);
  endtask
  // Status valid is set by completion and then stays.
  task automatic t_dv();
    chk(o_status_dv, 1'b0);
    @(posedge i_clk);
    i_all_txn_done <= 1'b1;
    @(posedge i_clk);
    i_all_txn_done <= 1'b0;
    #1 chk(o_status_dv, 1'b1);
    u_plc.rd(10'h000, s);
    chk(s, 8'h3f);
    repeat (10) @(posedge i_clk);
    #1 chk(o_status_dv, 1'b1);
  endtask
  // One report, its send toggle, the host confirm and the confirm echo.
  task automatic t_report();
    chk(o_report_ready, 1'b1);
    @(posedge i_clk);
    i_report_valid <= 1'b1;
    i_report_code <= 5'h01;
    i_report_data <= 8'h07;
    @(posedge i_clk);
    i_report_valid <= 1'b0;
    #1 chk(o_report_ready, 1'b0);
    u_plc.rd(10'h000, s);
    chk(s, 8'ha1);
    u_plc.rd(10'h001, s);
    chk(s, 8'h07);
    u_plc.wr(10'h200, 8'ha0);
    #1 chk(o_report_ready, 1'b1);
    u_plc.wr(10'h200, 8'he0);
    u_plc.rd(10'h000, s);
    chk(s, 8'he1);
  endtask
  // Offline from exchange restarts the handshake from the beginning.
  task automatic t_restart();
    u_plc.offline(8'h22);
    wait_exch(1'b0);
    u_plc.online(1'b1, ok);
    chk(ok, 1'b1);
    wait_exch(1'b1);
  endtask
  // Main sequence.
  initial begin
    i_rstn = 1'b0;
    i_words_en = 1'b0;
    i_startup_lock = 1'b0;
    i_all_txn_done = 1'b0;
    i_report_valid = 1'b0;
    i_report_code = 5'h00;
    i_report_data = 8'h00;
    repeat (16) @(posedge i_clk);
    i_rstn <= 1'b1;
    #1 t_reset();
    t_disabled();
    t_lock();
    t_dv();
    t_report();
    t_restart();
    results();
  end
  // Watchdog well beyond the expected run of under two hundred cycles.
  initial begin
    #500000;
    n_fail++;
    results();
  end
endmodule

// ### tb/gsc_plc_model.sv
// Purpose: Behavioural fieldbus control system driving the process-data bus.
// Assumes: One byte per strobe, strobes changed just after the rising edge.
// Notes: Address and data show inverted values when idle, so stale bytes never pass.
`timescale 1ns/1ps
module gsc_plc_model (
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  output logic [9:0] o_addr,
  output logic o_rd,
  output logic o_wr,
  output logic [7:0] o_wdata,
  output logic o_online
);
  // Idle bus values at time zero.
  initial begin
    o_addr = 10'h3ff;
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_wdata = 8'hff;
    o_online = 1'b0;
  end
  // One write; the strobe is taken at the edge after it rises.
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask
  // One read; the byte is settled just after the taking edge.
  task automatic rd(input logic [9:0] a, output logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clk);
    o_rd <= 1'b0;
    o_addr <= ~a;
    #1 d = i_rdata;
  endtask
  // Offline step: drop out, clear our valid bit, write initial output data.
  task automatic offline(input logic [7:0] init);
    @(posedge i_clk);
    o_online <= 1'b0;
    wr(10'h200, 8'h00);
    wr(10'h202, init);
  endtask
  // Online step; traffic is not held back for the gateway's valid bit.
  task automatic online(input bit set_dv, output bit ok);
    logic [7:0] s;
    @(posedge i_clk);
    o_online <= 1'b1;
    ok = 1'b0;
    for (int i = 0; i < 20 && !ok; i++) begin
      rd(10'h000, s);
      ok = (s[5] === 1'b0);
    end
    if (ok && set_dv) wr(10'h200, 8'h20);
  endtask
endmodule
